/* File: logic/counter_control_event_config.sv */
// control, channel configuration, debug and event control registers of the counter unit
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module counter_control_event_config #(
   parameter int NUM_CH = 2   // compare/capture channels
) (
   input wire logic clock,                         // 25 MHz system clock
   input wire logic sys_rst,                       // synchronous reset, high
   input wire logic [7:0] reg_addr,                // register address
   input wire logic [15:0] reg_wdata,              // write data
   input wire logic reg_wr,                        // write strobe
   input wire logic reg_rd,                        // read strobe
   output logic [15:0] reg_rdata,                  // read data, cycle after strobe
   input wire logic sw_reset,                      // software reset pulse
   input wire logic counter_enable,                // counter unit enabled
   input wire logic cnt_tick,                      // prescaled counter clock enable
   input wire logic debug_halt,                    // device halted in debug
   input wire logic wrap_hit,                      // overflow/underflow pulse
   input wire logic [NUM_CH-1:0] chan_hit,         // match or capture pulses
   input wire logic [NUM_CH-1:0] wave_raw,         // raw channel waveforms
   input wire logic event_in,                      // incoming event
   output logic retrigger_pulse,                   // start/restart request
   output logic stop_pulse,                        // stop request
   output logic counter_running,                   // run state
   output logic count_down,                        // direction
   output logic single_run,                        // single-run mode
   output logic [NUM_CH-1:0] capture_select,       // capture when high
   output logic [NUM_CH-1:0] waveform_out,         // waveform_out_x pins
   output logic counter_halt,                      // freeze for debug
   output logic [NUM_CH-1:0] channel_event_out,    // channel event pulses
   output logic wrap_event_out,                    // wrap event pulse
   output logic count_event,                       // count-on-event pulse
   output logic measure_active,                    // measurement mode on
   output logic measure_level,                     // shaped measurement level
   output logic [2:0] event_reaction               // active reaction code
);
   // refuse channel counts that the field layout cannot hold
   if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_ch
      $error("NUM_CH must be 1 or 2");
   end

   // address match helper
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic [1:0] cmd_r, cmd_nxt;               // pending command
   logic single_run_r, single_run_nxt;       // single-run bit
   logic dir_r, dir_nxt;                     // direction bit
   logic [NUM_CH-1:0] capt_r;                // capture_select_x
   logic [NUM_CH-1:0] inv_r;                 // output_invert_x
   logic run_in_debug_halt_r;                           // run_in_debug_halt
   logic [NUM_CH-1:0] ch_evo_r;              // channel event enables
   logic wrap_evo_r;                         // wrap event enable
   logic evi_en_r;                           // event_input_enable
   logic evi_inv_r;                          // event_input_invert
   logic [2:0] react_r;                      // event_reaction
   counter_ctl_pkg::run_state_t state_r;     // run state
   counter_ctl_pkg::run_state_t state_nxt;   // next run state
   logic wr_set, wr_clr, wr_c, wr_dbg, wr_ev; // write decodes
   logic tick_ok;                            // tick not frozen by debug
   logic exec;                               // command executes now
   logic do_retrig, do_stop;                 // decoded command actions
   logic halt_c;                             // halt condition
   logic [7:0] ctrlb_view;                   // shared control_b read view
   logic [15:0] rd_mux;                      // read mux
   logic [NUM_CH-1:0] chan_pad;              // channel enables padded
   event_link_if lnk ();                     // event bundle

   assign wr_set = reg_wr & hit(reg_addr, counter_ctl_pkg::ADDR_CTRLB_SET);
   assign wr_clr = reg_wr & hit(reg_addr, counter_ctl_pkg::ADDR_CTRLB_CLR);
   assign wr_c = reg_wr & hit(reg_addr, counter_ctl_pkg::ADDR_CTRL_C);
   assign wr_dbg = reg_wr & hit(reg_addr, counter_ctl_pkg::ADDR_DBG);
   assign wr_ev = reg_wr & hit(reg_addr, counter_ctl_pkg::ADDR_EVCTL);
   assign halt_c = debug_halt & ~run_in_debug_halt_r;
   assign tick_ok = cnt_tick & ~halt_c;
   assign exec = tick_ok & (cmd_r != counter_ctl_pkg::CMD_NONE);
   // reserved code gives neither action
   assign do_retrig = exec & (cmd_r == counter_ctl_pkg::CMD_RETRIG);
   assign do_stop = exec & (cmd_r == counter_ctl_pkg::CMD_STOP);

   // event shaper hookup
   assign lnk.ev_in = event_in;
   assign lnk.in_enable = evi_en_r;
   assign lnk.in_invert = evi_inv_r;
   assign lnk.reaction = counter_ctl_pkg::react_t'(react_r);
   event_input_shaper u_shaper (
      .lnk(lnk.shaper)
   );

   // next value of the shared control_b state; set beats clear
   always_comb begin
      cmd_nxt = cmd_r;
      single_run_nxt = single_run_r;
      dir_nxt = dir_r;
      if (exec) begin
         cmd_nxt = counter_ctl_pkg::CMD_NONE;
      end
      if (wr_clr) begin
         cmd_nxt = cmd_nxt & ~reg_wdata[counter_ctl_pkg::CMD_LSB +: 2];
         single_run_nxt = single_run_nxt & ~reg_wdata[counter_ctl_pkg::SINGLE_RUN_BIT];
         dir_nxt = dir_nxt & ~reg_wdata[counter_ctl_pkg::DIR_BIT];
      end
      if (wr_set) begin
         cmd_nxt = cmd_nxt | reg_wdata[counter_ctl_pkg::CMD_LSB +: 2];
         single_run_nxt = single_run_nxt | reg_wdata[counter_ctl_pkg::SINGLE_RUN_BIT];
         dir_nxt = dir_nxt | reg_wdata[counter_ctl_pkg::DIR_BIT];
      end
   end

   // control_b state register
   always_ff @(posedge clock) begin
      if (sys_rst || sw_reset) begin
         cmd_r <= counter_ctl_pkg::CMD_RST;
         single_run_r <= 1'b0;
         dir_r <= 1'b0;
      end else begin
         cmd_r <= cmd_nxt;
         single_run_r <= single_run_nxt;
         dir_r <= dir_nxt;
      end
   end

   // control_c: channel mode and inversion
   always_ff @(posedge clock) begin
      if (sys_rst || sw_reset) begin
         capt_r <= counter_ctl_pkg::CTRL_C_RST[counter_ctl_pkg::CAPT_LSB +: NUM_CH];
         inv_r <= counter_ctl_pkg::CTRL_C_RST[counter_ctl_pkg::INV_LSB +: NUM_CH];
      end else if (wr_c) begin
         capt_r <= reg_wdata[counter_ctl_pkg::CAPT_LSB +: NUM_CH];
         inv_r <= reg_wdata[counter_ctl_pkg::INV_LSB +: NUM_CH];
      end
   end

   // debug_control: kept across software reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         run_in_debug_halt_r <= 1'b0;
      end else if (wr_dbg) begin
         run_in_debug_halt_r <= reg_wdata[counter_ctl_pkg::RUN_IN_DEBUG_HALT_BIT];
      end
   end

   // event_control; reaction locked while enabled
   always_ff @(posedge clock) begin
      if (sys_rst || sw_reset) begin
         ch_evo_r <= '0;
         wrap_evo_r <= 1'b0;
         evi_en_r <= 1'b0;
         evi_inv_r <= 1'b0;
         react_r <= counter_ctl_pkg::REACT_RST;
      end else if (wr_ev) begin
         ch_evo_r <= reg_wdata[counter_ctl_pkg::CH_EVO_LSB +: NUM_CH];
         wrap_evo_r <= reg_wdata[counter_ctl_pkg::WRAP_EVO_BIT];
         evi_en_r <= reg_wdata[counter_ctl_pkg::EVI_EN_BIT];
         evi_inv_r <= reg_wdata[counter_ctl_pkg::EVI_INV_BIT];
         if (!counter_enable) begin
            react_r <= reg_wdata[counter_ctl_pkg::REACT_LSB +: 3];
         end
      end
   end

   // run state: stop has priority over any start
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         counter_ctl_pkg::ST_IDLE: begin
            if (!do_stop && (do_retrig || lnk.act_retrigger || lnk.act_start)) begin
               state_nxt = counter_ctl_pkg::ST_RUN;
            end
         end
         counter_ctl_pkg::ST_RUN: begin
            if (do_stop || (wrap_hit && single_run_r && !halt_c)) begin
               state_nxt = counter_ctl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = counter_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   // run state register
   always_ff @(posedge clock) begin
      if (sys_rst || sw_reset || !counter_enable) begin
         state_r <= counter_ctl_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // command pulses; a stop command suppresses a same-cycle retrigger
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         retrigger_pulse <= 1'b0;
         stop_pulse <= 1'b0;
      end else begin
         retrigger_pulse <= (do_retrig | (lnk.act_retrigger & ~halt_c)) & ~do_stop;
         stop_pulse <= do_stop | (wrap_hit & single_run_r & ~halt_c);
      end
   end

   // mode outputs and debug freeze
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         counter_running <= 1'b0;
         count_down <= 1'b0;
         single_run <= 1'b0;
         capture_select <= '0;
         counter_halt <= 1'b0;
         event_reaction <= counter_ctl_pkg::REACT_RST;
      end else begin
         counter_running <= (state_nxt == counter_ctl_pkg::ST_RUN) && counter_enable;
         count_down <= dir_r;
         single_run <= single_run_r;
         capture_select <= capt_r;
         counter_halt <= halt_c;
         event_reaction <= react_r;
      end
   end

   // per-channel waveform inversion and event output
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               waveform_out[i] <= 1'b0;
               channel_event_out[i] <= 1'b0;
            end else begin
               waveform_out[i] <= wave_raw[i] ^ inv_r[i];
               channel_event_out[i] <= chan_hit[i] & ch_evo_r[i];
            end
         end
      end
   endgenerate

   // wrap and incoming-event outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrap_event_out <= 1'b0;
         count_event <= 1'b0;
         measure_active <= 1'b0;
         measure_level <= 1'b0;
      end else begin
         wrap_event_out <= wrap_hit & wrap_evo_r;
         count_event <= lnk.act_count & (state_r == counter_ctl_pkg::ST_RUN) & ~halt_c;
         measure_active <= lnk.act_measure;
         measure_level <= lnk.meas_level & lnk.act_measure;
      end
   end

   // read mux; reserved bits and unmapped addresses read zero
   assign chan_pad = ch_evo_r;
   assign ctrlb_view = {cmd_r, 3'h0, single_run_r, 1'b0, dir_r};
   always_comb begin
      rd_mux = counter_ctl_pkg::RDATA_ZERO;
      if (hit(reg_addr, counter_ctl_pkg::ADDR_CTRLB_CLR) ||
          hit(reg_addr, counter_ctl_pkg::ADDR_CTRLB_SET)) begin
         rd_mux[7:0] = ctrlb_view;
      end else if (hit(reg_addr, counter_ctl_pkg::ADDR_CTRL_C)) begin
         rd_mux[counter_ctl_pkg::CAPT_LSB +: NUM_CH] = capt_r;
         rd_mux[counter_ctl_pkg::INV_LSB +: NUM_CH] = inv_r;
      end else if (hit(reg_addr, counter_ctl_pkg::ADDR_DBG)) begin
         rd_mux[counter_ctl_pkg::RUN_IN_DEBUG_HALT_BIT] = run_in_debug_halt_r;
      end else if (hit(reg_addr, counter_ctl_pkg::ADDR_EVCTL)) begin
         rd_mux[counter_ctl_pkg::CH_EVO_LSB +: NUM_CH] = chan_pad;
         rd_mux[counter_ctl_pkg::WRAP_EVO_BIT] = wrap_evo_r;
         rd_mux[counter_ctl_pkg::EVI_EN_BIT] = evi_en_r;
         rd_mux[counter_ctl_pkg::EVI_INV_BIT] = evi_inv_r;
         rd_mux[counter_ctl_pkg::REACT_LSB +: 3] = react_r;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= counter_ctl_pkg::RDATA_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= counter_ctl_pkg::RDATA_ZERO;
      end
   end

   // checks on the design's own behaviour
   AST_CMD_CLEARS: assert property (@(posedge clock) disable iff (sys_rst)
      (exec && !wr_set) |=> (cmd_r == counter_ctl_pkg::CMD_NONE))
      else $error("command not cleared after execution");
   AST_RETRIG_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
      (exec && cmd_r == counter_ctl_pkg::CMD_RETRIG && !sw_reset) |=> retrigger_pulse)
      else $error("retrigger command gave no pulse");
   AST_RSVD_QUIET: assert property (@(posedge clock) disable iff (sys_rst)
      (exec && cmd_r == counter_ctl_pkg::CMD_RSVD && !lnk.act_retrigger && !wrap_hit)
      |=> (!retrigger_pulse && !stop_pulse))
      else $error("reserved command had an effect");
   AST_SET_KEEPS: assert property (@(posedge clock) disable iff (sys_rst)
      (wr_set && !sw_reset && $past(cmd_r) == cmd_r && cmd_r[0] && !exec) |=> cmd_r[0])
      else $error("zero write to set register lost a command bit");
   AST_DIR_SET: assert property (@(posedge clock) disable iff (sys_rst)
      (wr_set && reg_wdata[counter_ctl_pkg::DIR_BIT] && !sw_reset) |=> ##1 count_down)
      else $error("direction set did not reach output");
   AST_REACT_LOCK: assert property (@(posedge clock) disable iff (sys_rst)
      (wr_ev && counter_enable && !sw_reset) |=> $stable(react_r))
      else $error("reaction changed while enabled");
   AST_DBG_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
      (sw_reset && !wr_dbg) |=> $stable(run_in_debug_halt_r))
      else $error("debug bit changed by software reset");
   AST_HALT: assert property (@(posedge clock) disable iff (sys_rst)
      (debug_halt && !run_in_debug_halt_r) |=> counter_halt)
      else $error("counter not halted in debug");
   AST_WRAP_EVT: assert property (@(posedge clock) disable iff (sys_rst)
      wrap_event_out |-> $past(wrap_hit) && $past(wrap_evo_r))
      else $error("wrap event without cause");
   AST_SINGLE_RUN_STOP: assert property (@(posedge clock) disable iff (sys_rst)
      (state_r == counter_ctl_pkg::ST_RUN && wrap_hit && single_run_r && !halt_c)
      |=> state_r == counter_ctl_pkg::ST_IDLE ##1 !counter_running)
      else $error("single-run did not stop on wrap");
   AST_RSVD_READ: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_rd && hit(reg_addr, counter_ctl_pkg::ADDR_CTRLB_SET)) |=> (reg_rdata[5:3] == 3'h0))
      else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

/* File: logic/counter_ctl_pkg.sv */
// constants, field layout and codes for the counter control and event block
package counter_ctl_pkg;
   localparam int ADDR_W = 8;                        // register address width
   localparam int DATA_W = 16;                       // register data width
   localparam logic [7:0] ADDR_CTRLB_CLR = 8'h04;    // control_b_clear offset
   localparam logic [7:0] ADDR_CTRLB_SET = 8'h05;    // control_b_set offset
   localparam logic [7:0] ADDR_CTRL_C = 8'h06;       // control_c offset
   localparam logic [7:0] ADDR_DBG = 8'h08;          // debug_control offset
   localparam logic [7:0] ADDR_EVCTL = 8'h0A;        // event_control offset
   localparam int CMD_LSB = 6;                       // command field low bit
   localparam int SINGLE_RUN_BIT = 2;                // single-run bit
   localparam int DIR_BIT = 0;                       // count direction bit
   localparam int CAPT_LSB = 4;                      // capture_select_x low bit
   localparam int INV_LSB = 0;                       // output_invert_x low bit
   localparam int RUN_IN_DEBUG_HALT_BIT = 0;                    // run_in_debug_halt bit
   localparam int CH_EVO_LSB = 12;                   // channel_event_out_x low bit
   localparam int WRAP_EVO_BIT = 8;                  // wrap_event_out enable bit
   localparam int EVI_EN_BIT = 5;                    // event_input_enable bit
   localparam int EVI_INV_BIT = 4;                   // event_input_invert bit
   localparam int REACT_LSB = 0;                     // event_reaction low bit
   localparam logic [1:0] CMD_RST = 2'h0;            // command reset value
   localparam logic [7:0] CTRL_C_RST = 8'h00;        // control_c reset value
   localparam logic [2:0] REACT_RST = 3'h0;          // event_reaction reset value
   localparam logic [15:0] RDATA_ZERO = 16'h0000;    // idle and unmapped read value
   // software command codes
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_RETRIG = 2'h1,
      CMD_STOP = 2'h2,
      CMD_RSVD = 2'h3
   } cmd_t;
   // event reaction codes
   typedef enum logic [2:0] {
      REACT_OFF = 3'h0,
      REACT_RETRIG = 3'h1,
      REACT_COUNT = 3'h2,
      REACT_START = 3'h3,
      REACT_RSVD4 = 3'h4,
      REACT_PPW = 3'h5,
      REACT_PWP = 3'h6,
      REACT_RSVD7 = 3'h7
   } react_t;
   // run state, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } run_state_t;
endpackage

/* File: logic/event_link_if.sv */
// bundle between the register block and the event input shaper
`timescale 1ns/100ps
`default_nettype none
interface event_link_if;
   logic ev_in;                        // incoming event from the event network
   logic in_enable;                    // event_input_enable
   logic in_invert;                    // event_input_invert
   counter_ctl_pkg::react_t reaction;  // selected event reaction
   logic act_retrigger;                // event asks for retrigger
   logic act_start;                    // event asks for start
   logic act_count;                    // event asks for one count
   logic act_measure;                  // measurement mode active
   logic meas_level;                   // event level for measurement
   modport shaper (input ev_in, in_enable, in_invert, reaction,
                   output act_retrigger, act_start, act_count, act_measure, meas_level);
   modport owner (output ev_in, in_enable, in_invert, reaction,
                  input act_retrigger, act_start, act_count, act_measure, meas_level);
endinterface
`default_nettype wire

/* File: logic/event_input_shaper.sv */
// gates and decodes the incoming event by the selected reaction, and inverts the measured level
`timescale 1ns/100ps
`default_nettype none
module event_input_shaper (
   event_link_if.shaper lnk   // event bundle
);
   logic ev_ok;   // event allowed through

   // incoming events act only while enabled
   assign ev_ok = lnk.ev_in & lnk.in_enable;

   // decode the reaction; reserved codes do nothing
   always_comb begin
      lnk.act_retrigger = 1'b0;
      lnk.act_start = 1'b0;
      lnk.act_count = 1'b0;
      lnk.act_measure = 1'b0;
      unique case (lnk.reaction)
         counter_ctl_pkg::REACT_RETRIG: begin
            lnk.act_retrigger = ev_ok;
         end
         counter_ctl_pkg::REACT_COUNT: begin
            lnk.act_count = ev_ok;
         end
         counter_ctl_pkg::REACT_START: begin
            lnk.act_start = ev_ok;
         end
         counter_ctl_pkg::REACT_PPW, counter_ctl_pkg::REACT_PWP: begin
            lnk.act_measure = lnk.in_enable;
         end
         default: begin
            lnk.act_measure = 1'b0;
         end
      endcase
   end

   // inversion applies to the measured level
   assign lnk.meas_level = (lnk.ev_in ^ lnk.in_invert) & lnk.in_enable;
endmodule
`default_nettype wire

/* File: bench/event_far_end.sv */
// far-end model: event network sources and raw waveforms
`timescale 1ns/100ps
`default_nettype none
module event_far_end (
   input wire logic clock, // system clock
   input wire logic [3:0] fire, // event level, chan 1..0, wrap
   output logic wrap_hit, // wrap pulse
   output logic [1:0] chan_hit, // channel pulses
   output logic [1:0] wave_raw, // raw waveforms
   output logic event_in // incoming event level
);
   // quiet at time zero
   initial begin
      wrap_hit = 1'h0;
      chan_hit = 2'h0;
      wave_raw = 2'h0;
      event_in = 1'h0;
   end
   // pulses last one cycle, raw waveforms count up by one every cycle
   always @(posedge clock) begin
      wrap_hit <= fire[0];
      chan_hit <= fire[2:1];
      wave_raw <= wave_raw + 2'h1;
      event_in <= fire[3];
   end
endmodule
`default_nettype wire

/* File: bench/test_counter_control_event_config.sv */
// self-checking bench for the counter control and event block
`timescale 1ns/100ps
`default_nettype none
module test_counter_control_event_config;
   logic clock, sys_rst, reg_wr, reg_rd, sw_reset, counter_enable, cnt_tick, debug_halt;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v;
   logic [3:0] fire;
   logic wrap_hit, event_in, rd_seen, retrigger_pulse, stop_pulse, counter_running;
   logic [1:0] chan_hit, wave_raw, wv, capture_select, waveform_out, channel_event_out;
   logic count_down, single_run, counter_halt, wrap_event_out, count_event;
   logic measure_active, measure_level;
   logic [2:0] event_reaction;
   logic [15:0] exp_q[$]; // expected read data, oldest first
   int fail_count = 0;
   int num_checks = 0;
   counter_control_event_config dut (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_reset(sw_reset),
      .counter_enable(counter_enable), .cnt_tick(cnt_tick), .debug_halt(debug_halt),
      .wrap_hit(wrap_hit), .chan_hit(chan_hit), .wave_raw(wave_raw), .event_in(event_in),
      .retrigger_pulse(retrigger_pulse), .stop_pulse(stop_pulse),
      .counter_running(counter_running), .count_down(count_down), .single_run(single_run),
      .capture_select(capture_select), .waveform_out(waveform_out),
      .counter_halt(counter_halt), .channel_event_out(channel_event_out),
      .wrap_event_out(wrap_event_out), .count_event(count_event),
      .measure_active(measure_active), .measure_level(measure_level),
      .event_reaction(event_reaction)
   );
   event_far_end far (
      .clock(clock), .fire(fire), .wrap_hit(wrap_hit), .chan_hit(chan_hit),
      .wave_raw(wave_raw), .event_in(event_in)
   );
   // free-running clock
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] e);
      @(posedge clock);
      reg_rd <= 1'h1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clock);
      reg_rd <= 1'h0;
   endtask
   // one prescaled tick, then look just after the executing edge
   task automatic tick();
      @(posedge clock);
      cnt_tick <= 1'h1;
      @(posedge clock);
      cnt_tick <= 1'h0;
      #1;
   endtask
   // far end fires, outputs looked at once the block has registered them
   task automatic ev(logic [3:0] f);
      @(posedge clock);
      fire <= f;
      @(posedge clock);
      fire <= 4'h0;
      @(posedge clock);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // read data monitor: takes the oldest note when data is due
   always @(posedge clock) begin
      if (rd_seen) begin
         chk("rdata", exp_q.pop_front(), reg_rdata);
      end
      rd_seen <= reg_rd;
   end
   // hang guard
   initial begin
      repeat (3000) @(posedge clock);
      fail_count++;
      conclude();
   end
   // main sequence
   initial begin
      {sys_rst, reg_wr, reg_rd, sw_reset, counter_enable, cnt_tick, debug_halt} = 7'h40;
      {reg_addr, reg_wdata, fire, rd_seen} = 29'h0;
      void'($urandom(32'h552EADAA));
      repeat (12) @(posedge clock);
      sys_rst <= 1'h0;
      foreach (v[i]) if (i < 5) rd(8'h04 + 8'(i * 2), 16'h0000);
      $display("reset values done");
      for (int i = 0; i < 2; i++) begin
         v = 16'($urandom()) & 16'h0033;
         v[1:0] = {2{i[0]}};
         wr(8'h06, v);
         rd(8'h06, v & 16'h0033);
         @(posedge clock);
         wv = wave_raw;
         #1;
         chk("wave", wv ^ v[1:0], waveform_out);
         chk("capt", v[5:4], capture_select);
      end
      $display("channel config done");
      debug_halt <= 1'h1;
      rd(8'h08, 16'h0000);
      chk("halt", 16'h1, counter_halt);
      wr(8'h08, 16'h0001); // written while disabled
      @(posedge clock);
      sw_reset <= 1'h1;
      @(posedge clock);
      sw_reset <= 1'h0;
      rd(8'h08, 16'h0001);
      rd(8'h06, 16'h0000);
      chk("halt", 16'h0, counter_halt);
      debug_halt <= 1'h0;
      $display("debug done");
      counter_enable <= 1'h1;
      wr(8'h0A, 16'h3137);
      rd(8'h0A, 16'h3130);
      ev(4'h7);
      chk("evout", 16'h7, {channel_event_out, wrap_event_out});
      wr(8'h0A, 16'h0000);
      ev(4'h7);
      chk("evout", 16'h0, {channel_event_out, wrap_event_out});
      counter_enable <= 1'h0;
      wr(8'h0A, 16'h0035);
      rd(8'h0A, 16'h0035);
      chk("meas", 16'h17, {event_reaction, measure_active, measure_level});
      $display("event control done");
      counter_enable <= 1'h1;
      wr(8'h05, 16'h0040);
      rd(8'h05, 16'h0040);
      tick();
      chk("retrig", 16'h1, retrigger_pulse);
      rd(8'h05, 16'h0000);
      wr(8'h05, 16'h00C0);
      tick();
      chk("rsvd", 16'h1, {retrigger_pulse, stop_pulse, counter_running});
      wr(8'h05, 16'h0080);
      tick();
      chk("stop", 16'h1, stop_pulse);
      rd(8'h05, 16'h0000);
      chk("run", 16'h0, counter_running);
      counter_enable <= 1'h0;
      wr(8'h0A, 16'h0021);
      counter_enable <= 1'h1;
      wr(8'h05, 16'h0080);
      @(posedge clock);
      fire <= 4'h8;
      @(posedge clock);
      fire <= 4'h0;
      cnt_tick <= 1'h1;
      @(posedge clock);
      cnt_tick <= 1'h0;
      #1;
      chk("prio", 16'h2, {retrigger_pulse, stop_pulse, counter_running});
      wr(8'h05, 16'h0005);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'h0005);
      chk("mode", 16'h3, {single_run, count_down});
      wr(8'h05, 16'h0040);
      tick();
      ev(4'h1);
      rd(8'h05, 16'h0005);
      chk("single_run", 16'h0, counter_running);
      wr(8'h04, 16'h0005);
      rd(8'h05, 16'h0000);
      counter_enable <= 1'h0;
      wr(8'h0A, 16'h0022);
      counter_enable <= 1'h1;
      wr(8'h05, 16'h0040);
      tick();
      ev(4'h8);
      chk("count", 16'h1, count_event);
      $display("commands done");
      repeat (3) @(posedge clock);
      conclude();
   end
endmodule
`default_nettype wire
